// ### core/mb_diag_pkg.sv
/*
 * constants, area codes, error codes and the outcome carrier for the
 * serial-gateway diagnosis block.
 * assumes a 25 MHz system clock and a frame engine that reports one
 * outcome per slot transaction.
 */
package mb_diag_pkg;
  // clock and timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int POLL_UNIT_MS = 1;
  localparam int MS_CYCLES    = CLK_HZ / 1000 * POLL_UNIT_MS;
  localparam int MAX_SLOTS    = 48;

  // register byte offsets
  localparam logic [5:0] OFS_CTRL  = 6'h00;
  localparam logic [5:0] OFS_SEL   = 6'h04;
  localparam logic [5:0] OFS_CFG   = 6'h08;
  localparam logic [5:0] OFS_STLO  = 6'h0C;
  localparam logic [5:0] OFS_STHI  = 6'h10;
  localparam logic [5:0] OFS_ERR   = 6'h14;
  localparam logic [5:0] OFS_MCLO  = 6'h18;
  localparam logic [5:0] OFS_MCHI  = 6'h1C;
  localparam logic [5:0] OFS_POLL  = 6'h20;
  localparam logic [5:0] OFS_FLAGS = 6'h24;

  // control bit positions and slot config layout
  localparam int CTRL_ROLE  = 0;
  localparam int CTRL_MCEN  = 1;
  localparam int CTRL_EDGE  = 2;
  localparam int CTRL_CLRTO = 3;
  localparam int CFG_SINGLE = 3;
  localparam int CFG_SIZE   = 4;
  localparam logic [14:0] CFG_RESET = 15'h0000;

  // size limits
  localparam logic [10:0] MBIT_MIN = 11'h008, MBIT_MAX = 11'h0C8;
  localparam logic [10:0] MWRD_MIN = 11'h001, MWRD_MAX = 11'h07D;
  localparam logic [10:0] SBYT_MAX = 11'h400, SWRD_MAX = 11'h200;
  localparam logic [10:0] PDU_WRD  = 11'h07D, PDU_BIT  = 11'h7D0;

  typedef enum logic [2:0] {
    AREA_COIL_RD = 3'b000, AREA_DI_RD = 3'b001, AREA_IR_RD = 3'b010,
    AREA_HR_RD   = 3'b011, AREA_COIL_WR = 3'b100, AREA_HR_WR = 3'b101,
    AREA_DI_WR   = 3'b110, AREA_IR_WR = 3'b111
  } area_type;

  // error code table
  localparam logic [7:0] EC_OK = 8'h00, EC_FUNC = 8'h01, EC_ADDR = 8'h02;
  localparam logic [7:0] EC_VAL = 8'h03, EC_PROC = 8'h04, EC_APLEN = 8'h05;
  localparam logic [7:0] EC_PID = 8'h06, EC_BUF = 8'h07, EC_BIT = 8'h08;
  localparam logic [7:0] EC_ID = 8'h09, EC_CRC = 8'h0A, EC_LRC = 8'h0B;
  localparam logic [7:0] EC_RFC = 8'h0C, EC_RADR = 8'h0D, EC_RLEN = 8'h0E;
  localparam logic [7:0] EC_TMO = 8'h0F, EC_COLON = 8'h10, EC_CRLF = 8'h11;
  localparam logic [7:0] EC_HEX = 8'h12, EC_CNT = 8'h13, EC_HW = 8'h14;

  typedef struct packed {
    logic hw;        logic timeout;  logic colon;   logic crlf;
    logic nonhex;    logic count;    logic crc;     logic lrc;
    logic id_mis;    logic pid;      logic app_len; logic fc_mis;
    logic addr_mis;  logic len_mis;  logic buf_adr; logic bit_ofs;
  } fault_type;

  // one transaction outcome from the frame engine
  typedef struct packed {
    logic [5:0]  slot;
    logic [7:0]  func;
    logic [7:0]  exc;
    logic [10:0] len;
    fault_type   fault;
  } outcome_type;
endpackage : mb_diag_pkg

// ### core/mb_diag.sv
/*
 * diagnosis and command-gating layer of a serial Modbus gateway port:
 * slot configuration checks, per-slot fault bits and error codes,
 * module-control gating and polling-time measurement, on Avalon-MM.
 * assumes a frame engine that pulses cmd_start_i when a slot command
 * goes out, outcome_valid_i with the outcome and cycle_start_i per poll.
 */
`timescale 1ns/10ps
module mb_diag #(
  parameter int NUM_SLOTS = 48,
  parameter int MS_CYC    = mb_diag_pkg::MS_CYCLES
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     nrst_i,
  input  wire logic [5:0]               avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  output logic      [31:0]              avs_readdata_o,
  output logic                          avs_waitrequest_o,
  input  wire logic                     cmd_start_i,
  input  wire logic [5:0]               cmd_slot_i,
  input  wire logic                     outcome_valid_i,
  input  wire mb_diag_pkg::outcome_type outcome_i,
  input  wire logic                     cycle_start_i,
  output logic      [NUM_SLOTS-1:0]     slot_status_o,
  output logic      [NUM_SLOTS-1:0]     cmd_allow_o,
  output logic                          clear_data_o,
  output logic      [5:0]               clear_slot_o
);
  typedef struct packed {
    logic                      wait_req;
    logic [31:0]               rdata;
    logic                      role;
    logic                      mc_en;
    logic                      edge_md;
    logic                      clr_to;
    logic [5:0]                sel;
    logic [NUM_SLOTS-1:0][14:0] cfg;
    logic [NUM_SLOTS-1:0]      stat;
    logic [NUM_SLOTS-1:0][7:0] fc;
    logic [NUM_SLOTS-1:0][7:0] ec;
    logic [63:0]               mc;
    logic [NUM_SLOTS-1:0]      mc_q;
    logic [NUM_SLOTS-1:0]      pend;
    logic [NUM_SLOTS-1:0]      allow;
    logic                      clr_v;
    logic [5:0]                clr_slot;
    logic [15:0]               poll_ms;
    logic [15:0]               ms_cnt;
    logic [15:0]               div;
    logic                      cfg_rej;
  } state_type;

  state_type st;
  state_type next_st;

  // configured size legal for the port role and area
  function automatic logic size_ok(input logic role, input logic [14:0] c);
    logic [10:0] sz;
    logic        sgl;
    sz  = c[mb_diag_pkg::CFG_SIZE +: 11];
    sgl = c[mb_diag_pkg::CFG_SINGLE];
    size_ok = 1'b0;
    if (!role) begin
      case (mb_diag_pkg::area_type'(c[2:0]))
        mb_diag_pkg::AREA_COIL_RD, mb_diag_pkg::AREA_DI_RD:
          size_ok = sz >= mb_diag_pkg::MBIT_MIN && sz <= mb_diag_pkg::MBIT_MAX;
        mb_diag_pkg::AREA_IR_RD, mb_diag_pkg::AREA_HR_RD:
          size_ok = sz >= mb_diag_pkg::MWRD_MIN && sz <= mb_diag_pkg::MWRD_MAX;
        mb_diag_pkg::AREA_COIL_WR:
          size_ok = sgl || (sz >= mb_diag_pkg::MBIT_MIN &&
                            sz <= mb_diag_pkg::MBIT_MAX);
        mb_diag_pkg::AREA_HR_WR:
          size_ok = sgl || (sz >= mb_diag_pkg::MWRD_MIN &&
                            sz <= mb_diag_pkg::MWRD_MAX);
        default: size_ok = 1'b0;
      endcase
    end else begin
      case (mb_diag_pkg::area_type'(c[2:0]))
        mb_diag_pkg::AREA_COIL_RD, mb_diag_pkg::AREA_COIL_WR:
          size_ok = sz >= 11'h001 && sz <= mb_diag_pkg::SBYT_MAX;
        mb_diag_pkg::AREA_DI_WR:
          size_ok = sz >= 11'h008 && sz <= mb_diag_pkg::SBYT_MAX;
        mb_diag_pkg::AREA_HR_RD, mb_diag_pkg::AREA_IR_WR,
        mb_diag_pkg::AREA_HR_WR:
          size_ok = sz >= 11'h001 && sz <= mb_diag_pkg::SWRD_MAX;
        default: size_ok = 1'b0;
      endcase
    end
  endfunction : size_ok

  // outcome to error code; link faults first, remote exceptions last
  function automatic logic [7:0] err_code(input mb_diag_pkg::outcome_type o);
    logic big;
    big = (o.func <= 8'h02 || o.func == 8'h0F) ? o.len > mb_diag_pkg::PDU_BIT
                                               : o.len > mb_diag_pkg::PDU_WRD;
    if (o.fault.hw)            err_code = mb_diag_pkg::EC_HW;
    else if (o.fault.timeout)  err_code = mb_diag_pkg::EC_TMO;
    else if (o.fault.colon)    err_code = mb_diag_pkg::EC_COLON;
    else if (o.fault.crlf)     err_code = mb_diag_pkg::EC_CRLF;
    else if (o.fault.nonhex)   err_code = mb_diag_pkg::EC_HEX;
    else if (o.fault.count)    err_code = mb_diag_pkg::EC_CNT;
    else if (o.fault.crc)      err_code = mb_diag_pkg::EC_CRC;
    else if (o.fault.lrc)      err_code = mb_diag_pkg::EC_LRC;
    else if (o.fault.id_mis)   err_code = mb_diag_pkg::EC_ID;
    else if (o.fault.pid)      err_code = mb_diag_pkg::EC_PID;
    else if (o.fault.app_len)  err_code = mb_diag_pkg::EC_APLEN;
    else if (o.fault.fc_mis)   err_code = mb_diag_pkg::EC_RFC;
    else if (o.fault.addr_mis) err_code = mb_diag_pkg::EC_RADR;
    else if (o.fault.len_mis)  err_code = mb_diag_pkg::EC_RLEN;
    else if (o.fault.buf_adr)  err_code = mb_diag_pkg::EC_BUF;
    else if (o.fault.bit_ofs)  err_code = mb_diag_pkg::EC_BIT;
    else if (big)              err_code = mb_diag_pkg::EC_VAL;
    else if (o.exc == 8'h01)   err_code = mb_diag_pkg::EC_FUNC;
    else if (o.exc == 8'h02)   err_code = mb_diag_pkg::EC_ADDR;
    else if (o.exc == 8'h03)   err_code = mb_diag_pkg::EC_VAL;
    else if (o.exc != 8'h00)   err_code = mb_diag_pkg::EC_PROC;
    else                       err_code = mb_diag_pkg::EC_OK;
  endfunction : err_code

  logic       acc;
  logic [7:0] code;
  logic [5:0] oslot;
  logic       ms_tick;

  // next-state logic for bus, slots, gating and poll timer
  always_comb begin
    next_st = st;
    acc     = (avs_read_i || avs_write_i) && !st.wait_req;
    code    = err_code(outcome_i);
    // slave role has one external master: all faults land on slot 0
    oslot   = st.role ? 6'h00 : outcome_i.slot;
    ms_tick = st.div == 16'(MS_CYC - 1);

    // one wait cycle, then answer; back to waiting after the handshake
    next_st.wait_req = 1'b1;
    if ((avs_read_i || avs_write_i) && st.wait_req) begin
      next_st.wait_req = 1'b0;
      next_st.rdata    = 32'h0000_0000;
      if (avs_address_i == mb_diag_pkg::OFS_CTRL) begin
        next_st.rdata[3:0] = {st.clr_to, st.edge_md, st.mc_en, st.role};
      end else if (avs_address_i == mb_diag_pkg::OFS_SEL) begin
        next_st.rdata[5:0] = st.sel;
      end else if (avs_address_i == mb_diag_pkg::OFS_CFG) begin
        next_st.rdata[14:0] = st.cfg[st.sel];
      end else if (avs_address_i == mb_diag_pkg::OFS_STLO) begin
        next_st.rdata = 32'(64'(st.stat));
      end else if (avs_address_i == mb_diag_pkg::OFS_STHI) begin
        next_st.rdata = 32'(64'(st.stat) >> 32);
      end else if (avs_address_i == mb_diag_pkg::OFS_ERR) begin
        next_st.rdata[15:0] = {st.fc[st.sel], st.ec[st.sel]};
      end else if (avs_address_i == mb_diag_pkg::OFS_MCLO) begin
        next_st.rdata = st.mc[31:0];
      end else if (avs_address_i == mb_diag_pkg::OFS_MCHI) begin
        next_st.rdata = st.mc[63:32];
      end else if (avs_address_i == mb_diag_pkg::OFS_POLL) begin
        next_st.rdata[15:0] = st.poll_ms;
      end else if (avs_address_i == mb_diag_pkg::OFS_FLAGS) begin
        next_st.rdata[0] = st.cfg_rej;
      end
    end

    // register writes take effect at the completing edge
    if (acc && avs_write_i) begin
      if (avs_address_i == mb_diag_pkg::OFS_CTRL) begin
        next_st.role    = avs_writedata_i[mb_diag_pkg::CTRL_ROLE];
        next_st.mc_en   = avs_writedata_i[mb_diag_pkg::CTRL_MCEN];
        next_st.edge_md = avs_writedata_i[mb_diag_pkg::CTRL_EDGE];
        next_st.clr_to  = avs_writedata_i[mb_diag_pkg::CTRL_CLRTO];
      end else if (avs_address_i == mb_diag_pkg::OFS_SEL) begin
        if (avs_writedata_i[5:0] < 6'(NUM_SLOTS))
          next_st.sel = avs_writedata_i[5:0];
      end else if (avs_address_i == mb_diag_pkg::OFS_CFG) begin
        // illegal size leaves old config and raises the reject flag
        if (size_ok(st.role, avs_writedata_i[14:0]))
          next_st.cfg[st.sel] = avs_writedata_i[14:0];
        else
          next_st.cfg_rej = 1'b1;
      end else if (avs_address_i == mb_diag_pkg::OFS_MCLO) begin
        next_st.mc[31:0] = avs_writedata_i;
      end else if (avs_address_i == mb_diag_pkg::OFS_MCHI) begin
        next_st.mc[63:32] = avs_writedata_i;
      end else if (avs_address_i == mb_diag_pkg::OFS_FLAGS) begin
        if (avs_writedata_i[0] && next_st.cfg_rej == st.cfg_rej)
          next_st.cfg_rej = 1'b0;
      end
    end

    // command gating: level mode follows the channel, edge mode arms once
    next_st.mc_q = st.mc[NUM_SLOTS-1:0];
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (cmd_start_i && cmd_slot_i == 6'(i))
        next_st.pend[i] = 1'b0;
      if (st.mc[i] && !st.mc_q[i])
        next_st.pend[i] = 1'b1;
      if (!st.mc_en)
        next_st.allow[i] = 1'b1;
      else if (st.edge_md)
        next_st.allow[i] = next_st.pend[i];
      else
        next_st.allow[i] = st.mc[i];
    end

    // outcome bookkeeping; a good completion clears the slot
    next_st.clr_v = 1'b0;
    if (outcome_valid_i && oslot < 6'(NUM_SLOTS)) begin
      next_st.stat[oslot] = code != mb_diag_pkg::EC_OK;
      next_st.ec[oslot]   = code;
      next_st.fc[oslot]   = outcome_i.func;
      if (outcome_i.fault.timeout && st.clr_to && !st.role &&
          !st.cfg[oslot][2]) begin
        next_st.clr_v    = 1'b1;
        next_st.clr_slot = oslot;
      end
    end

    // millisecond divider and poll cycle capture, saturating
    next_st.div = ms_tick ? 16'h0000 : st.div + 16'h0001;
    if (ms_tick && st.ms_cnt != 16'hFFFF)
      next_st.ms_cnt = st.ms_cnt + 16'h0001;
    if (cycle_start_i) begin
      next_st.poll_ms = st.ms_cnt;
      next_st.ms_cnt  = 16'h0000;
      next_st.div     = 16'h0000; // whole ms from the cycle start
    end
  end

  // single state register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st          <= '0;
      st.wait_req <= 1'b1;
      st.allow    <= '1;
      for (int i = 0; i < NUM_SLOTS; i++)
        st.cfg[i] <= mb_diag_pkg::CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata_o    = st.rdata;
  assign avs_waitrequest_o = st.wait_req;
  assign slot_status_o     = st.stat;
  assign cmd_allow_o       = st.allow;
  assign clear_data_o      = st.clr_v;
  assign clear_slot_o      = st.clr_slot;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  logic wr_cfg;
  assign wr_cfg = acc && avs_write_i && avs_address_i == mb_diag_pkg::OFS_CFG;

  // outcome that lands on a slot; rising control bits arm in edge mode
  logic                 oslot_ok;
  logic [NUM_SLOTS-1:0] mc_rise;
  assign oslot_ok = outcome_valid_i && oslot < 6'(NUM_SLOTS);
  assign mc_rise  = st.mc[NUM_SLOTS-1:0] & ~st.mc_q;

  sequence s_good_done;
    oslot_ok && !st.role && code == mb_diag_pkg::EC_OK;
  endsequence
  sequence s_slot_clean;
    !st.stat[$past(outcome_i.slot)] ##0 st.ec[$past(outcome_i.slot)] == 8'h00;
  endsequence
  sequence s_edge_start;
    st.mc_en && st.edge_md && cmd_start_i &&
    cmd_slot_i < 6'(NUM_SLOTS) && !mc_rise[cmd_slot_i];
  endsequence
  sequence s_edge_rise;
    st.mc_en && st.edge_md && |mc_rise;
  endsequence

  a_bus_one_wait: assert property (!st.wait_req |=> st.wait_req)
    else $error("waitrequest low for more than one cycle");
  a_cfg_bit_reject: assert property (
    wr_cfg && !st.role && avs_writedata_i[2:0] == 3'b000 &&
    avs_writedata_i[14:4] == 11'h007 |=> st.cfg_rej)
    else $error("coil read size 7 accepted");
  a_cfg_word_reject: assert property (
    wr_cfg && !st.role && avs_writedata_i[2:0] == 3'b011 &&
    avs_writedata_i[14:4] == 11'h07E |=> st.cfg_rej)
    else $error("register read size 126 accepted");
  a_cfg_single_ok: assert property (
    wr_cfg && !st.role && avs_writedata_i[3:0] == 4'b1100 |=>
    st.cfg[$past(st.sel)] == $past(avs_writedata_i[14:0]))
    else $error("single coil write config refused");
  a_fault_sets: assert property (
    oslot_ok && !st.role && code != 8'h00 |=>
    st.stat[$past(outcome_i.slot)] && slot_status_o[$past(outcome_i.slot)])
    else $error("faulty slot bit not set");
  a_good_clears: assert property (s_good_done |=> s_slot_clean)
    else $error("good completion left fault on slot");
  a_code_timeout: assert property (
    oslot_ok && !st.role && outcome_i.fault.timeout &&
    !outcome_i.fault.hw |=> st.ec[$past(outcome_i.slot)] == 8'h0F)
    else $error("timeout not coded 0x0F");
  a_code_crc: assert property (
    oslot_ok && !st.role && outcome_i.fault == 16'h0200 |=>
    st.ec[$past(outcome_i.slot)] == 8'h0A)
    else $error("crc fault not coded 0x0A");
  a_gate_level: assert property (
    st.mc_en && !st.edge_md |=> cmd_allow_o == $past(st.mc[NUM_SLOTS-1:0]))
    else $error("level gating does not follow control");
  a_gate_off: assert property (!st.mc_en |=> &cmd_allow_o)
    else $error("gating active while disabled");
  a_hold_default: assert property (
    !st.clr_to |=> !clear_data_o)
    else $error("input cleared while hold is set");
  a_poll_capture: assert property (
    cycle_start_i |=> st.poll_ms == $past(st.ms_cnt) ##0 st.ms_cnt == 16'h0)
    else $error("poll time not captured");

  // edge mode: a rising channel arms, a sent command disarms
  a_edge_arm: assert property (s_edge_rise |=>
    (cmd_allow_o & $past(mc_rise)) == $past(mc_rise))
    else $error("rising control bit did not arm slot");
  a_edge_disarm: assert property (
    s_edge_start |=> !cmd_allow_o[$past(cmd_slot_i)])
    else $error("sent command left slot armed");

  // slave role: one external master, all faults on slot 0
  a_slave_slot0: assert property (
    outcome_valid_i && st.role && code != 8'h00 |=>
    slot_status_o[0] && st.ec[0] == $past(code))
    else $error("slave fault not on slot 0");

  // timeout clearing and per-slot bookkeeping
  a_clear_read: assert property (
    oslot_ok && st.clr_to && !st.role && outcome_i.fault.timeout &&
    !st.cfg[outcome_i.slot][2] |=>
    clear_data_o && clear_slot_o == $past(outcome_i.slot))
    else $error("timeout did not clear read slot");
  a_func_kept: assert property (
    oslot_ok && !st.role |=>
    st.fc[$past(outcome_i.slot)] == $past(outcome_i.func))
    else $error("function code not kept");
  a_code_exc: assert property (
    oslot_ok && !st.role && outcome_i.fault == 16'h0000 &&
    outcome_i.exc == 8'h01 && outcome_i.len <= 11'h07D |=>
    st.ec[$past(outcome_i.slot)] == 8'h01)
    else $error("rejected function not coded 0x01");
  a_stat_code: assert property (
    oslot_ok |=>
    slot_status_o[$past(oslot)] == (st.ec[$past(oslot)] != 8'h00))
    else $error("status bit disagrees with error code");
endmodule : mb_diag

// ### dv/mb_far_side.sv
/*
 * far-side model: stands for the frame engine and the serial devices,
 * turning one bench request into a command pulse, then an outcome pulse.
 * assumes one request at a time, raised for a single clock.
 */
`timescale 1ns/10ps
module mb_far_side (
  input  wire logic                     sys_clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     req_i,
  input  wire logic [3:0]               delay_i,
  input  wire mb_diag_pkg::outcome_type req_outcome_i,
  output logic                          cmd_start_o,
  output logic      [5:0]               cmd_slot_o,
  output logic                          outcome_valid_o,
  output mb_diag_pkg::outcome_type      outcome_o
);
  logic                     busy;
  logic [3:0]               wait_cnt;
  mb_diag_pkg::outcome_type held;

  // reply after a set wait; the outcome bus garbles off the strobe so a
  // block that samples it late sees junk rather than a stale copy
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy            <= 1'b0;
      wait_cnt        <= 4'h0;
      held            <= '0;
      cmd_start_o     <= 1'b0;
      cmd_slot_o      <= 6'h00;
      outcome_valid_o <= 1'b0;
      outcome_o       <= '0;
    end else begin
      cmd_start_o     <= req_i;
      cmd_slot_o      <= req_i ? req_outcome_i.slot : ~cmd_slot_o;
      outcome_valid_o <= busy && (wait_cnt == 4'h0);
      outcome_o       <= (busy && wait_cnt == 4'h0) ? held : ~outcome_o;
      if (req_i) begin
        busy     <= 1'b1;
        wait_cnt <= delay_i;
        held     <= req_outcome_i;
      end else if (busy) begin
        busy     <= (wait_cnt != 4'h0);
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule : mb_far_side

// ### dv/mb_diag_tb.sv
/*
 * self-checking bench for the diagnosis block, one task per scenario.
 * assumes a ms unit cut to 10 cycles and the far-side model beside it.
 */
`timescale 1ns/10ps
module mb_diag_tb;
  logic                     sys_clk_i;
  logic                     nrst_i;
  logic [5:0]               address;
  logic                     rd;
  logic                     wr;
  logic [31:0]              wdata;
  logic [31:0]              rdata;
  logic                     waitreq;
  logic                     req;
  logic [3:0]               delay;
  mb_diag_pkg::outcome_type req_out;
  logic                     cmd_start;
  logic [5:0]               cmd_slot;
  logic                     out_valid;
  mb_diag_pkg::outcome_type out_bus;
  logic                     cyc_start;
  logic [47:0]              status;
  logic [47:0]              allow;
  logic                     clr;
  logic [5:0]               clr_slot;
  logic [6:0]               clr_seen;
  logic [31:0]              q;
  int                       err_count;
  int                       num_checks;
  // expected code per fault flag, lowest flag first
  logic [7:0]  code_tab [0:15] = '{8'h08, 8'h07, 8'h0E, 8'h0D, 8'h0C,
    8'h05, 8'h06, 8'h09, 8'h0B, 8'h0A, 8'h13, 8'h12, 8'h11, 8'h10,
    8'h0F, 8'h14};
  // slot config words {size, single, area} and {slave role, accepted}
  logic [14:0] cfg_w [0:15] = '{15'h0070, 15'h0080, 15'h0C81, 15'h0C91,
    15'h0003, 15'h07D2, 15'h07E3, 15'h001C, 15'h0074, 15'h001D, 15'h07E5,
    15'h4000, 15'h4014, 15'h0076, 15'h2013, 15'h2007};
  logic [1:0]  cfg_m [0:15] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0,
    2'h1, 2'h0, 2'h1, 2'h0, 2'h3, 2'h2, 2'h2, 2'h2, 2'h3};

  mb_diag #(.NUM_SLOTS(48), .MS_CYC(10)) mb_diag_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(address),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .cmd_start_i(cmd_start), .cmd_slot_i(cmd_slot),
    .outcome_valid_i(out_valid), .outcome_i(out_bus),
    .cycle_start_i(cyc_start), .slot_status_o(status),
    .cmd_allow_o(allow), .clear_data_o(clr), .clear_slot_o(clr_slot));

  mb_far_side mb_far_side_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req), .delay_i(delay),
    .req_outcome_i(req_out), .cmd_start_o(cmd_start),
    .cmd_slot_o(cmd_slot), .outcome_valid_o(out_valid),
    .outcome_o(out_bus));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one bus cycle; holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    address <= a;
    wdata   <= d;
    wr      <= w;
    rd      <= !w;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk(n, 32'h2); // exactly one wait cycle
  endtask : bus

  task automatic send(input logic [5:0] s, input logic [7:0] f,
                      input logic [7:0] e, input logic [10:0] l,
                      input logic [15:0] flt);
    @(posedge sys_clk_i);
    req     <= 1'b1;
    req_out <= {s, f, e, l, flt};
    @(posedge sys_clk_i);
    req <= 1'b0;
    @(posedge sys_clk_i iff out_valid);
    #1;
    clr_seen = {clr, clr_slot};
  endtask : send

  task automatic t_reset;
    chk({16'h0, allow[47:32]}, 32'h0000FFFF);
    bus(1'b1, 6'h30, 32'hFFFFFFFF);
    bus(1'b0, 6'h30, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, mb_diag_pkg::OFS_STLO, 32'h0);
    chk(q, 32'h0);
  endtask : t_reset

  task automatic t_config;
    logic [14:0] last;
    last = 15'h0000;
    bus(1'b1, mb_diag_pkg::OFS_SEL, 32'h2);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, mb_diag_pkg::OFS_CTRL, {31'h0, cfg_m[i][1]});
      bus(1'b1, mb_diag_pkg::OFS_CFG, {17'h0, cfg_w[i]});
      if (cfg_m[i][0]) last = cfg_w[i];
      bus(1'b0, mb_diag_pkg::OFS_CFG, 32'h0);
      chk(q, {17'h0, last});
      bus(1'b0, mb_diag_pkg::OFS_FLAGS, 32'h0);
      chk(q, {31'h0, ~cfg_m[i][0]});
      bus(1'b1, mb_diag_pkg::OFS_FLAGS, 32'h1);
    end
    bus(1'b1, mb_diag_pkg::OFS_CTRL, 32'h0);
  endtask : t_config

  // every fault flag, remote exceptions, oversize lengths, then recovery
  task automatic t_codes;
    bus(1'b1, mb_diag_pkg::OFS_SEL, 32'h3);
    for (int i = 0; i < 16; i++) begin
      send(6'h03, 8'h03, 8'h00, 11'h00A, 16'h0001 << i);
      bus(1'b0, mb_diag_pkg::OFS_ERR, 32'h0);
      chk(q, {16'h0, 8'h03, code_tab[i]});
      chk(status[31:0], 32'h8);
    end
    for (int i = 1; i < 5; i++) begin
      send(6'h03, 8'h03, i[7:0], 11'h00A, 16'h0);
      bus(1'b0, mb_diag_pkg::OFS_ERR, 32'h0);
      chk(q, {24'h000003, i[7:0]});
    end
    send(6'h03, 8'h03, 8'h00, 11'h07E, 16'h0);
    bus(1'b0, mb_diag_pkg::OFS_ERR, 32'h0);
    chk(q, 32'h00000303);
    send(6'h03, 8'h01, 8'h00, 11'h7D1, 16'h0);
    bus(1'b0, mb_diag_pkg::OFS_ERR, 32'h0);
    chk(q, 32'h00000103);
    send(6'h03, 8'h01, 8'h00, 11'h7D0, 16'h0);
    bus(1'b0, mb_diag_pkg::OFS_ERR, 32'h0);
    chk(q, 32'h00000100);
    chk(status[31:0], 32'h0);
  endtask : t_codes

  task automatic t_timeout;
    bus(1'b1, mb_diag_pkg::OFS_CTRL, 32'h8);
    send(6'h03, 8'h01, 8'h00, 11'h008, 16'h4000);
    chk({25'h0, clr_seen}, 32'h43);
    bus(1'b0, mb_diag_pkg::OFS_STLO, 32'h0);
    chk(q, 32'h8);
    bus(1'b1, mb_diag_pkg::OFS_CTRL, 32'h0);
    send(6'h03, 8'h01, 8'h00, 11'h008, 16'h4000);
    chk({31'h0, clr_seen[6]}, 32'h0);
    send(6'h03, 8'h01, 8'h00, 11'h008, 16'h0);
    chk(status[31:0], 32'h0);
  endtask : t_timeout

  task automatic t_gating;
    bus(1'b1, mb_diag_pkg::OFS_MCLO, 32'hFFFFFFFE);
    bus(1'b1, mb_diag_pkg::OFS_MCHI, 32'h0000FFFE);
    repeat (2) @(posedge sys_clk_i);
    chk(allow[31:0], 32'hFFFFFFFF);
    bus(1'b1, mb_diag_pkg::OFS_CTRL, 32'h2);
    repeat (2) @(posedge sys_clk_i);
    chk(allow[31:0], 32'hFFFFFFFE);
    chk({16'h0, allow[47:32]}, 32'h0000FFFE);
    bus(1'b1, mb_diag_pkg::OFS_CTRL, 32'h6);
    send(6'h03, 8'h03, 8'h00, 11'h00A, 16'h0);
    chk(allow[31:0], 32'hFFFFFFF6);
    bus(1'b1, mb_diag_pkg::OFS_MCLO, 32'hFFFFFFF6);
    bus(1'b1, mb_diag_pkg::OFS_MCLO, 32'hFFFFFFFE);
    repeat (2) @(posedge sys_clk_i);
    chk(allow[31:0], 32'hFFFFFFFE);
    bus(1'b1, mb_diag_pkg::OFS_CTRL, 32'h0);
  endtask : t_gating

  // two cycle starts 36 clocks apart at 10 clocks per ms
  task automatic t_poll;
    @(posedge sys_clk_i);
    cyc_start <= 1'b1;
    @(posedge sys_clk_i);
    cyc_start <= 1'b0;
    repeat (35) @(posedge sys_clk_i);
    cyc_start <= 1'b1;
    @(posedge sys_clk_i);
    cyc_start <= 1'b0;
    bus(1'b0, mb_diag_pkg::OFS_POLL, 32'h0);
    chk(q, 32'h3);
  endtask : t_poll

  // slow far side; slave role folds every outcome onto slot 0
  task automatic t_slave;
    delay <= 4'h9;
    bus(1'b1, mb_diag_pkg::OFS_CTRL, 32'h1);
    send(6'h05, 8'h03, 8'h00, 11'h00A, 16'h0200);
    bus(1'b1, mb_diag_pkg::OFS_SEL, 32'h0);
    bus(1'b0, mb_diag_pkg::OFS_ERR, 32'h0);
    chk(q, 32'h0000030A);
    chk(status[31:0], 32'h1);
    send(6'h05, 8'h03, 8'h00, 11'h00A, 16'h0);
    chk(status[31:0], 32'h0);
  endtask : t_slave

  task automatic complete_run;
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    nrst_i     = 1'b0;
    address    = 6'h00;
    rd         = 1'b0;
    wr         = 1'b0;
    wdata      = 32'h0;
    req        = 1'b0;
    delay      = 4'h2;
    req_out    = '0;
    cyc_start  = 1'b0;
    err_count  = 0;
    num_checks = 0;
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_reset;
    t_config;
    t_codes;
    t_timeout;
    t_gating;
    t_poll;
    t_slave;
    complete_run;
  end

  // scenarios need under a thousand clocks; ten thousand means a hang
  initial begin
    #400000;
    err_count++;
    complete_run;
  end
endmodule : mb_diag_tb
